// [aqc_pkg.sv]
// Constants for the analog quad configuration byte bank.
// Assumes the port is driven by fabric logic on the same clock.
package aqc_pkg;

    // ****************************************
    // Geometry and address map
    // ****************************************
    localparam int          NUM_QUADS       = 10;
    localparam int          BYTES_PER_QUAD  = 4;
    localparam int          NUM_BYTES       = NUM_QUADS * BYTES_PER_QUAD;
    localparam logic [7:0]  QUAD_ADDR_FIRST = 8'h01;
    localparam logic [7:0]  QUAD_ADDR_LAST  = 8'h28;
    localparam logic [7:0]  RTC_ADDR_FIRST  = 8'h40;
    localparam logic [7:0]  RTC_ADDR_LAST   = 8'h59;

    // ****************************************
    // Byte order inside a quad
    // ****************************************
    localparam int          BYTE_VOLTAGE_PAD     = 0;
    localparam int          BYTE_CURRENT_PAD     = 1;
    localparam int          BYTE_GATE_DRIVER_PAD = 2;
    localparam int          BYTE_TEMPERATURE_PAD = 3;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int          BIT_SCALE_LSB   = 0;
    localparam int          BIT_SCALE_MSB   = 2;
    localparam int          BIT_MUX_LO      = 3;
    localparam int          BIT_MUX_HI      = 4;
    localparam int          BIT_CUR_MON_SW  = 4;
    localparam int          BIT_DIRECT_SW   = 5;
    localparam int          BIT_POLARITY    = 6;
    localparam int          BIT_OPAMP_ON    = 7;
    localparam int          BIT_TEMP_MON_ON = 0;
    localparam int          BIT_DRIVE_LSB   = 2;
    localparam int          BIT_DRIVE_MSB   = 3;
    localparam int          BIT_GATE_POL    = 6;
    localparam int          BIT_HIGH_DRIVE  = 7;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0]  VOLTAGE_PAD_RESET     = 8'h00;
    localparam logic [7:0]  CURRENT_PAD_RESET     = 8'h00;
    localparam logic [7:0]  GATE_DRIVER_RESET     = 8'h00;
    localparam logic [7:0]  TEMPERATURE_PAD_RESET = 8'h00;
    localparam logic [7:0]  READ_DATA_RESET       = 8'h00;

    // ****************************************
    // Prescaler ranges and converter routing
    // ****************************************
    localparam logic [15:0] FULL_SCALE_TOP_MV = 16'h3e80;

    typedef enum logic [1:0]
    {
        ROUTE_PRESCALER = 2'b00,
        ROUTE_DIRECT    = 2'b01,
        ROUTE_MONITOR   = 2'b10,
        ROUTE_INVALID   = 2'b11
    } aqc_route_type;

    typedef enum logic
    {
        TG_IDLE     = 1'b0,
        TG_WAIT_OSC = 1'b1
    } aqc_tg_state_type;

    function automatic logic [15:0] aqc_range_mv(input logic [2:0] code);
        return FULL_SCALE_TOP_MV >> code;
    endfunction : aqc_range_mv

    function automatic logic [7:0] aqc_byte_reset(input int sel);
        case (sel)
            BYTE_VOLTAGE_PAD:     return VOLTAGE_PAD_RESET;
            BYTE_CURRENT_PAD:     return CURRENT_PAD_RESET;
            BYTE_GATE_DRIVER_PAD: return GATE_DRIVER_RESET;
            default:              return TEMPERATURE_PAD_RESET;
        endcase
    endfunction : aqc_byte_reset

endpackage : aqc_pkg

// [aqc_config_bank.sv]
// Analog quad configuration byte bank behind the configuration port.
// Assumes fabric logic on clk drives the port; oscillator is asynchronous.
//
// Operation
// RL1: Counter addresses bypass timing generator and enables.
// RL2: Latches hold defaults until overwritten.
// RL3: Four bytes per quad: voltage, current, gate, temperature.
// RL4: Bits 2:0 scale, bits 4:3 mux select.
// RL5: Bit 5 direct switch; voltage bit 4 monitor.
// RL6: Bit 7 op-amp mode; bit 6 pad polarity.
// RL7: Gate byte: monitor, drive current, polarity, strength.
// RL8: Defaults: 16 V, prescaler, off, positive, down.
// RL9: Scale codes map 16 V down to 0.125 V.
// RL10: Controller clocks port at most 10 MHz; the bench clocks it at 25 MHz.
// RL11: Controller limits temperature pad scaling codes.
// RL12: Temperature pad codes only 000 or 010.
// RL13: Addresses 1-40 quads, 64-89 counter.
// RL14: Mux bits 4:3 route converter input.
// RL15: Controller keeps temperature pad bit 6 zero.
// RL16: Spare bits stored and read back unchanged.
`timescale 1ns/1ps

module aqc_config_bank
    import aqc_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // Configuration port
    input  wire logic [7:0]                 configPortAddress,
    input  wire logic [7:0]                 portWriteData,
    input  wire logic                       portWriteEn,
    input  wire logic                       portReadEn,
    input  wire logic                       byteEnable,
    input  wire logic                       quadWriteEnable,
    input  wire logic                       internalOscillatorInput,
    output logic [7:0]                      portReadData,
    output logic                            portBusy,
    // Counter side
    output logic                            rtcWriteStrobe,
    output logic                            rtcReadStrobe,
    output logic [7:0]                      rtcAddress,
    output logic [7:0]                      rtcWriteData,
    input  wire logic [7:0]                 rtcReadData,
    // Decoded quad controls
    output logic [3*NUM_QUADS-1:0]          voltagePadScale,
    output logic [3*NUM_QUADS-1:0]          currentPadScale,
    output logic [3*NUM_QUADS-1:0]          temperaturePadScale,
    output logic [16*NUM_QUADS-1:0]         voltagePadRangeMv,
    output logic [2*NUM_QUADS-1:0]          voltagePadRoute,
    output logic [2*NUM_QUADS-1:0]          currentPadRoute,
    output logic [2*NUM_QUADS-1:0]          temperaturePadRoute,
    output logic [NUM_QUADS-1:0]            routeInvalid,
    output logic [NUM_QUADS-1:0]            currentMonitorSwitch,
    output logic [3*NUM_QUADS-1:0]          directSwitch,
    output logic [NUM_QUADS-1:0]            voltagePadNegative,
    output logic [NUM_QUADS-1:0]            currentPadNegative,
    output logic [3*NUM_QUADS-1:0]          opAmpOn,
    output logic [NUM_QUADS-1:0]            chipTempMonitorOn,
    output logic [2*NUM_QUADS-1:0]          gateDriveCurrent,
    output logic [NUM_QUADS-1:0]            gateDriverNegative,
    output logic [NUM_QUADS-1:0]            gateHighDrive
);

    // ****************************************
    // Address decode
    // ****************************************
    logic [7:0]             cfg_ff [NUM_BYTES];
    logic [7:0]             addrOffset;
    logic [5:0]             byteIndex;
    logic                   inQuad;
    logic                   inRtc;
    logic                   acceptWrite;
    logic                   oscSync1_ff;
    logic                   oscSync2_ff;
    logic                   oscPrev_ff;
    logic                   oscRise;
    logic                   commit;
    logic [5:0]             pendIndex_ff;
    logic [7:0]             pendData_ff;
    logic [7:0]             portReadData_ff;
    logic                   rtcWriteStrobe_ff;
    logic [7:0]             rtcAddress_ff;
    logic [7:0]             rtcWriteData_ff;
    aqc_tg_state_type       tgState_ff;
    aqc_tg_state_type       nxt_tgState;

    assign addrOffset = configPortAddress - QUAD_ADDR_FIRST;
    assign byteIndex  = addrOffset[5:0];
    assign inQuad     = (configPortAddress >= QUAD_ADDR_FIRST)
                        && (configPortAddress <= QUAD_ADDR_LAST);  // see RL13
    assign inRtc      = (configPortAddress >= RTC_ADDR_FIRST)
                        && (configPortAddress <= RTC_ADDR_LAST);   // see RL13

    // ****************************************
    // Oscillator synchroniser and edge detect
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            oscSync1_ff <= 1'b0;
            oscSync2_ff <= 1'b0;
            oscPrev_ff  <= 1'b0;
        end
        else
        begin
            oscSync1_ff <= internalOscillatorInput;
            oscSync2_ff <= oscSync1_ff;
            oscPrev_ff  <= oscSync2_ff;
        end
    end

    assign oscRise = oscSync2_ff && !oscPrev_ff;

    // ****************************************
    // Timing generator for quad writes
    // ****************************************
    assign acceptWrite = portWriteEn && inQuad && byteEnable && quadWriteEnable
                         && (tgState_ff == TG_IDLE);
    assign commit      = (tgState_ff == TG_WAIT_OSC) && oscRise;
    assign portBusy    = (tgState_ff == TG_WAIT_OSC);

    always_comb
    begin
        nxt_tgState = tgState_ff;
        case (tgState_ff)
            TG_IDLE:     if (acceptWrite) nxt_tgState = TG_WAIT_OSC;
            TG_WAIT_OSC: if (oscRise) nxt_tgState = TG_IDLE;
            default:     nxt_tgState = TG_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tgState_ff   <= TG_IDLE;
            pendIndex_ff <= 6'h00;
            pendData_ff  <= 8'h00;
        end
        else
        begin
            tgState_ff <= nxt_tgState;
            if (acceptWrite)
            begin
                pendIndex_ff <= byteIndex;
                pendData_ff  <= portWriteData;
            end
        end
    end

    // ****************************************
    // Configuration latches
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < NUM_BYTES; i++)
                cfg_ff[i] <= aqc_byte_reset(i % BYTES_PER_QUAD);  // see RL2 see RL8
        end
        else if (commit)
        begin
            cfg_ff[pendIndex_ff] <= pendData_ff;  // see RL16
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
            portReadData_ff <= READ_DATA_RESET;
        else if (portReadEn)
        begin
            if (inQuad)
                portReadData_ff <= cfg_ff[byteIndex];  // see RL16
            else if (inRtc)
                portReadData_ff <= rtcReadData;        // see RL1
            else
                portReadData_ff <= READ_DATA_RESET;
        end
    end

    assign portReadData = portReadData_ff;

    // ****************************************
    // Counter pass-through
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rtcWriteStrobe_ff <= 1'b0;
            rtcAddress_ff     <= 8'h00;
            rtcWriteData_ff   <= 8'h00;
        end
        else
        begin
            rtcWriteStrobe_ff <= portWriteEn && inRtc;  // see RL1
            if (portWriteEn && inRtc)
            begin
                rtcAddress_ff   <= configPortAddress;
                rtcWriteData_ff <= portWriteData;
            end
        end
    end

    assign rtcWriteStrobe = rtcWriteStrobe_ff;
    assign rtcReadStrobe  = portReadEn && inRtc;  // see RL1
    assign rtcAddress     = rtcAddress_ff;
    assign rtcWriteData   = rtcWriteData_ff;

    // ****************************************
    // Per-quad decode
    // ****************************************
    for (genvar q = 0; q < NUM_QUADS; q++)
    begin : g_quad
        logic [7:0] vByte;
        logic [7:0] cByte;
        logic [7:0] gByte;
        logic [7:0] tByte;

        assign vByte = cfg_ff[q*BYTES_PER_QUAD + BYTE_VOLTAGE_PAD];       // see RL3
        assign cByte = cfg_ff[q*BYTES_PER_QUAD + BYTE_CURRENT_PAD];       // see RL3
        assign gByte = cfg_ff[q*BYTES_PER_QUAD + BYTE_GATE_DRIVER_PAD];   // see RL3
        assign tByte = cfg_ff[q*BYTES_PER_QUAD + BYTE_TEMPERATURE_PAD];   // see RL3

        assign voltagePadScale[3*q +: 3]     = vByte[BIT_SCALE_MSB:BIT_SCALE_LSB];  // see RL4
        assign currentPadScale[3*q +: 3]     = cByte[BIT_SCALE_MSB:BIT_SCALE_LSB];  // see RL4
        assign temperaturePadScale[3*q +: 3] = tByte[BIT_SCALE_MSB:BIT_SCALE_LSB];  // see RL4
        assign voltagePadRangeMv[16*q +: 16] = aqc_range_mv(vByte[BIT_SCALE_MSB:BIT_SCALE_LSB]);  // see RL9

        assign voltagePadRoute[2*q +: 2]     = vByte[BIT_MUX_HI:BIT_MUX_LO];  // see RL4 see RL14
        assign currentPadRoute[2*q +: 2]     = cByte[BIT_MUX_HI:BIT_MUX_LO];  // see RL14
        assign temperaturePadRoute[2*q +: 2] = tByte[BIT_MUX_HI:BIT_MUX_LO];  // see RL14
        assign routeInvalid[q] = (vByte[BIT_MUX_HI:BIT_MUX_LO] == ROUTE_INVALID)
                                 || (cByte[BIT_MUX_HI:BIT_MUX_LO] == ROUTE_INVALID)
                                 || (tByte[BIT_MUX_HI:BIT_MUX_LO] == ROUTE_INVALID);  // see RL14

        assign currentMonitorSwitch[q] = vByte[BIT_CUR_MON_SW];  // see RL5
        assign directSwitch[3*q]       = vByte[BIT_DIRECT_SW];   // see RL5
        assign directSwitch[3*q+1]     = cByte[BIT_DIRECT_SW];   // see RL5
        assign directSwitch[3*q+2]     = tByte[BIT_DIRECT_SW];   // see RL5

        assign voltagePadNegative[q] = vByte[BIT_POLARITY];  // see RL6
        assign currentPadNegative[q] = cByte[BIT_POLARITY];  // see RL6
        assign opAmpOn[3*q]          = vByte[BIT_OPAMP_ON];  // see RL6
        assign opAmpOn[3*q+1]        = cByte[BIT_OPAMP_ON];  // see RL6
        assign opAmpOn[3*q+2]        = tByte[BIT_OPAMP_ON];  // see RL6

        assign chipTempMonitorOn[q]       = gByte[BIT_TEMP_MON_ON];                 // see RL7
        assign gateDriveCurrent[2*q +: 2] = gByte[BIT_DRIVE_MSB:BIT_DRIVE_LSB];     // see RL7
        assign gateDriverNegative[q]      = gByte[BIT_GATE_POL];                    // see RL7
        assign gateHighDrive[q]           = gByte[BIT_HIGH_DRIVE];                  // see RL7
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_RTC_NO_TIMING: assert property ( // see RL1
        (portWriteEn && inRtc && tgState_ff == TG_IDLE) |=> (tgState_ff == TG_IDLE))
        else $error("Counter write started the timing generator");
    AST_RTC_STROBE: assert property ( // see RL1
        (portWriteEn && inRtc) |=> (rtcWriteStrobe && rtcWriteData == $past(portWriteData)))
        else $error("Counter write not passed through");
    AST_HOLD_NO_COMMIT: assert property ( // see RL2
        !commit |=> (cfg_ff[0] == $past(cfg_ff[0])))
        else $error("Latch changed without a commit");
    AST_DEFAULTS: assert property ( // see RL8
        $rose(resetn) |-> (voltagePadScale == '0 && opAmpOn == '0 && gateHighDrive == '0))
        else $error("Latches not at defaults after reset");
    AST_COMMIT_STORE: assert property ( // see RL16
        commit |=> (cfg_ff[$past(pendIndex_ff)] == $past(pendData_ff)))
        else $error("Committed byte not stored");
    AST_QUAD0_VOLTAGE: assert property ( // see RL3
        (commit && pendIndex_ff == 6'h00) |=> (voltagePadScale[2:0] == $past(pendData_ff[2:0])
                                              && voltagePadNegative[0] == $past(pendData_ff[6])))
        else $error("Address one does not reach the first voltage byte");
    AST_WRITE_LATENCY: assert property ( // see RL13
        (acceptWrite || (portBusy && !oscRise)) |=> portBusy)
        else $error("Busy dropped before oscillator edge");
    AST_RANGE: assert property ( // see RL9
        (voltagePadScale[2:0] == 3'h7) |-> (voltagePadRangeMv[15:0] == 16'h007d))
        else $error("Lowest range is not 125 mV");
    AST_ROUTE_BAD: assert property ( // see RL14
        (currentPadRoute[1:0] == 2'b11) |-> routeInvalid[0])
        else $error("Invalid route not flagged");
    AST_READBACK: assert property ( // see RL16
        (portReadEn && inQuad) |=> (portReadData == $past(cfg_ff[byteIndex])))
        else $error("Read data does not match latch");
    AST_NO_ENABLE: assert property ( // see RL13
        (portWriteEn && inQuad && !quadWriteEnable) |-> !acceptWrite)
        else $error("Quad write taken without enable");

    COV_QUAD_WRITE: cover property (acceptWrite ##[1:40] commit);
    COV_RTC_WRITE:  cover property (portWriteEn && inRtc);
    COV_READBACK:   cover property (commit ##[1:10] (portReadEn && inQuad));
    COV_INVALID:    cover property (routeInvalid != '0);

endmodule : aqc_config_bank

// [aqc_counter_model.sv]
// Counter-side model behind the counter range of the configuration port.
// Assumes the bench hands over the port address for counter reads.
`timescale 1ns/1ps

module aqc_counter_model
(
    // Clock
    input  wire logic       clk,
    // Counter side of the bank
    input  wire logic       rtcWriteStrobe,
    input  wire logic       rtcReadStrobe,
    input  wire logic [7:0] rtcAddress,
    input  wire logic [7:0] rtcWriteData,
    input  wire logic [7:0] readAddress,
    output logic [7:0]      rtcReadData
);
    logic [7:0] mem [0:255];
    logic [7:0] lastData_ff = 8'h00;

    // ****************************************
    // Counter byte store
    // ****************************************
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
    end

    always @(posedge clk)
    begin
        if (rtcWriteStrobe)
        begin
            mem[rtcAddress] <= rtcWriteData;
        end
        lastData_ff <= rtcReadData;
    end

    // Unselected bus toggles so stale data never matches
    assign rtcReadData = rtcReadStrobe ? mem[readAddress] : ~lastData_ff;
endmodule : aqc_counter_model

// [test_analog_quad_config_bank.sv]
// Self-checking bench for the analog quad configuration byte bank.
// Assumes the counter model answers counter-range reads.
`timescale 1ns/1ps

module test_analog_quad_config_bank;
    import aqc_pkg::*;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] data;
    } aqc_row_type;

    logic                   clk = 1'b0, resetn = 1'b0, oscRun = 1'b1;
    logic [7:0]             configPortAddress = 8'h00, portWriteData = 8'h00;
    logic                   portWriteEn = 1'b0, portReadEn = 1'b0, byteEnable = 1'b0;
    logic                   quadWriteEnable = 1'b0, internalOscillatorInput = 1'b0;
    logic [7:0]             portReadData, rtcAddress, rtcWriteData, rtcReadData;
    logic                   portBusy, rtcWriteStrobe, rtcReadStrobe;
    logic [3*NUM_QUADS-1:0] voltagePadScale, currentPadScale, temperaturePadScale, directSwitch, opAmpOn;
    logic [16*NUM_QUADS-1:0] voltagePadRangeMv;
    logic [2*NUM_QUADS-1:0] voltagePadRoute, currentPadRoute, temperaturePadRoute, gateDriveCurrent;
    logic [NUM_QUADS-1:0]   routeInvalid, currentMonitorSwitch, voltagePadNegative, currentPadNegative;
    logic [NUM_QUADS-1:0]   chipTempMonitorOn, gateDriverNegative, gateHighDrive;
    int                     miscompares = 0;
    int                     n_tests = 0;
    logic [7:0]             sh [0:NUM_BYTES-1];
    aqc_row_type            rows [0:14] = '{'{8'h01, 8'hf5}, '{8'h02, 8'h4b}, '{8'h03, 8'hcd}, '{8'h04, 8'h1a},
        '{8'h06, 8'h2c}, '{8'h27, 8'h32}, '{8'h28, 8'h82}, '{8'h05, 8'h80}, '{8'h09, 8'h81}, '{8'h0d, 8'h82},
        '{8'h11, 8'h83}, '{8'h15, 8'h84}, '{8'h19, 8'h85}, '{8'h1d, 8'h86}, '{8'h21, 8'h87}};

    aqc_config_bank aqc_config_bank_inst (.clk, .resetn, .configPortAddress, .portWriteData, .portWriteEn,
        .portReadEn, .byteEnable, .quadWriteEnable, .internalOscillatorInput, .portReadData, .portBusy,
        .rtcWriteStrobe, .rtcReadStrobe, .rtcAddress, .rtcWriteData, .rtcReadData, .voltagePadScale,
        .currentPadScale, .temperaturePadScale, .voltagePadRangeMv, .voltagePadRoute, .currentPadRoute,
        .temperaturePadRoute, .routeInvalid, .currentMonitorSwitch, .directSwitch, .voltagePadNegative,
        .currentPadNegative, .opAmpOn, .chipTempMonitorOn, .gateDriveCurrent, .gateDriverNegative, .gateHighDrive);

    aqc_counter_model aqc_counter_model_inst (.clk, .rtcWriteStrobe, .rtcReadStrobe, .rtcAddress,
        .rtcWriteData, .readAddress(configPortAddress), .rtcReadData);

    // ****************************************
    // Clocks and shared tasks
    // ****************************************
    initial forever #20 clk = ~clk;
    // Oscillator edges kept off both clock edges
    initial #10 forever #160 if (oscRun) internalOscillatorInput = ~internalOscillatorInput;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        foreach (sh[i]) sh[i] = 8'h00;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic be, input logic qe);
        int n;
        @(negedge clk);
        configPortAddress = a;
        portWriteData = d;
        portWriteEn = 1'b1;
        byteEnable = be;
        quadWriteEnable = qe;
        @(negedge clk);
        portWriteEn = 1'b0;
        n = 0;
        while (portBusy !== 1'b0 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        check("busyDone", n < 100, 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        configPortAddress = a;
        portReadEn = 1'b1;
        #1;
        check("rdStrobe", rtcReadStrobe, a >= 8'h40 && a <= 8'h59);
        @(negedge clk);
        portReadEn = 1'b0;
        check("readData", portReadData, exp);
    endtask : rd

    task automatic check_all();
        logic [7:0] v, c, g, t;
        for (int q = 0; q < NUM_QUADS; q++)
        begin
            v = sh[4*q];
            c = sh[4*q+1];
            g = sh[4*q+2];
            t = sh[4*q+3];
            check("vScale", voltagePadScale[3*q+:3], v[2:0]);
            check("cScale", currentPadScale[3*q+:3], c[2:0]);
            check("tScale", temperaturePadScale[3*q+:3], t[2:0]);
            check("rangeMv", voltagePadRangeMv[16*q+:16], 16'd16000 >> v[2:0]);
            check("route", {voltagePadRoute[2*q+:2], currentPadRoute[2*q+:2], temperaturePadRoute[2*q+:2]},
                {v[4:3], c[4:3], t[4:3]});
            check("routeBad", routeInvalid[q], &v[4:3] | &c[4:3] | &t[4:3]);
            check("switches", {currentMonitorSwitch[q], directSwitch[3*q+:3]}, {v[4], t[5], c[5], v[5]});
            check("polOpAmp", {voltagePadNegative[q], currentPadNegative[q], opAmpOn[3*q+:3]},
                {v[6], c[6], t[7], c[7], v[7]});
            check("gate", {chipTempMonitorOn[q], gateDriveCurrent[2*q+:2], gateDriverNegative[q], gateHighDrive[q]},
                {g[0], g[3:2], g[6], g[7]});
        end
        for (int i = 0; i < NUM_BYTES; i++) rd(i + 1, sh[i]);
    endtask : check_all

    // ****************************************
    // Watchdog and main sequence
    // ****************************************
    initial
    begin
        #400000;
        miscompares++;
        final_report();
    end

    initial
    begin
        do_reset();
        check_all();
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].data, 1'b1, 1'b1);
            sh[rows[i].addr - 1] = rows[i].data;
            rd(rows[i].addr, rows[i].data);
        end
        check_all();
        wr(8'h07, 8'haa, 1'b0, 1'b1);
        wr(8'h07, 8'haa, 1'b1, 1'b0);
        wr(8'h00, 8'hff, 1'b1, 1'b1);
        wr(8'h29, 8'hff, 1'b1, 1'b1);
        rd(8'h00, 8'h00);
        rd(8'h29, 8'h00);
        rd(8'h3f, 8'h00);
        rd(8'h5a, 8'h00);
        rd(8'hff, 8'h00);
        rd(8'h07, 8'h00);
        oscRun = 1'b0;
        repeat (10) @(negedge clk);
        configPortAddress = 8'h0b;
        portWriteData = 8'h01;
        portWriteEn = 1'b1;
        @(negedge clk);
        check("busy", portBusy, 1'b1);
        configPortAddress = 8'h0c;
        portWriteData = 8'h02;
        @(negedge clk);
        portWriteEn = 1'b0;
        rd(8'h0b, 8'h00);
        foreach (rows[i]) if (i < 2)
        begin
            @(negedge clk);
            configPortAddress = i ? 8'h59 : 8'h40;
            portWriteData = i ? 8'hc3 : 8'h5a;
            portWriteEn = 1'b1;
            byteEnable = 1'b0;
            quadWriteEnable = 1'b0;
            @(negedge clk);
            portWriteEn = 1'b0;
            check("rtcWr", {rtcWriteStrobe, rtcAddress, rtcWriteData}, {1'b1, i ? 16'h59c3 : 16'h405a});
            @(negedge clk);
            check("rtcWrEnd", rtcWriteStrobe, 1'b0);
        end
        rd(8'h59, 8'hc3);
        rd(8'h40, 8'h5a);
        oscRun = 1'b1;
        wr(8'h0b, 8'h01, 1'b1, 1'b1);
        sh[10] = 8'h01;
        check_all();
        do_reset();
        check_all();
        final_report();
    end
endmodule : test_analog_quad_config_bank
